// File: design/slc_defs.svh
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

// clock and base tick
`define SLC_CLK_MHZ 125
`define SLC_TICK_US 1000
`define SLC_TICK_CYC (`SLC_TICK_US * `SLC_CLK_MHZ)

// timing in ms / s and derived tick counts (rounded down)
`define SLC_EDM_TIMEOUT_MS 300
`define SLC_EDM_TICKS (`SLC_EDM_TIMEOUT_MS * 1000 / `SLC_TICK_US)
`define SLC_SHOW_MS 500
`define SLC_SHOW_TICKS (`SLC_SHOW_MS * 1000 / `SLC_TICK_US)
`define SLC_SEG_STEP_MS 100
`define SLC_STEP_TICKS (`SLC_SEG_STEP_MS * 1000 / `SLC_TICK_US)
`define SLC_ALIGN_HOLD_S 120
`define SLC_ALIGN_TICKS (`SLC_ALIGN_HOLD_S * 1000000 / `SLC_TICK_US)

// pin sync vector bit positions
`define SLC_PIN_FB 0
`define SLC_PIN_BTN 1
`define SLC_PIN_TEST 2
`define SLC_PIN_ROLE 3

// reset values of configuration
`define SLC_RST_RESTART_IL 1'b0
`define SLC_RST_EDM 1'b0
`define SLC_RST_CFG 1'b0
`define SLC_RST_CODING 2'h0
// pin sync reset: test input idles at 24 V, so no false test request
`define SLC_RST_PINS 5'h04

// segment patterns, bit7 = dp, bits 6..0 = g..a
`define SLC_SEG_BLANK 8'h00
`define SLC_SEG_RANGE 8'h76
`define SLC_SEG_HOST 8'h74
`define SLC_SEG_GUEST1 8'h38
`define SLC_SEG_GUEST2 8'h3e
`define SLC_SEG_CODE0 8'h54
`define SLC_SEG_CODE1 8'h01
`define SLC_SEG_CODE2 8'h08
`define SLC_SEG_MARK 8'h5c
`define SLC_SEG_ALIGN0 8'hbf
`define SLC_SEG_ALIGN1 8'h86
`define SLC_SEG_ALIGN2 8'h5b
`define SLC_SEG_ERROR 8'hf9

`endif

// File: design/slc_pkg.sv
package slc_pkg;
  typedef enum logic [2:0] {
    SF_OFF = 3'h0, SF_ARMED = 3'h1, SF_CHECK = 3'h3, SF_ON = 3'h2,
    SF_ERR = 3'h6
  } slc_safe_t;
  typedef enum logic [2:0] {
    DS_TEST = 3'h0, DS_RANGE = 3'h1, DS_ROLE = 3'h3, DS_CODE = 3'h2,
    DS_ALIGN = 3'h6, DS_RUN = 3'h7, DS_ERR = 3'h5
  } slc_disp_t;
endpackage

// File: design/slc_disp_if.sv
`timescale 1ns/100ps
interface slc_disp_if;
  logic tick;
  logic receiver;
  logic large_range;
  logic marker;
  logic error;
  logic [1:0] align_q;
  logic [1:0] role;
  logic [1:0] coding;
  logic [7:0] seg;
  logic ready;
  modport ctrl (output tick, receiver, large_range, marker, error,
    align_q, role, coding, input seg, ready);
  modport disp (input tick, receiver, large_range, marker, error,
    align_q, role, coding, output seg, ready);
endinterface

// File: design/slc_disp.sv
`timescale 1ns/100ps
`include "slc_defs.svh"
module slc_disp
  import slc_pkg::*;
#(
  parameter int ALIGN_TICKS = `SLC_ALIGN_TICKS
)
(
  input wire logic core_clk,
  input wire logic reset,
  slc_disp_if.disp dif
);
  localparam logic [16:0] SHOW_T = 17'(`SLC_SHOW_TICKS);
  localparam logic [16:0] STEP_T = 17'(`SLC_STEP_TICKS);
  localparam logic [16:0] ALIGN_T = 17'(ALIGN_TICKS);

  if (ALIGN_TICKS < 1 || ALIGN_TICKS >= 131072)
  begin : g_bad_align
    $error("ALIGN_TICKS out of range");
  end

  slc_disp_t state_ff, nxt_state;
  logic [16:0] cnt_ff;
  logic [2:0] step_ff;
  logic [7:0] seg_ff;
  logic ready_ff;
  logic last;
  logic good;

  assign good = (dif.align_q == 2'h3);
  assign last = dif.tick &&
    (cnt_ff >= ((state_ff == DS_TEST) ? STEP_T : SHOW_T) - 17'h1);

  // power-up steps in fixed order, error overrides everything
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      DS_TEST:
        if (last && step_ff == 3'h6)
          nxt_state = (dif.receiver && dif.large_range) ? DS_RANGE
            : DS_ROLE;
      DS_RANGE: if (last) nxt_state = DS_ROLE;
      DS_ROLE: if (last) nxt_state = DS_CODE;
      DS_CODE: if (last) nxt_state = dif.receiver ? DS_ALIGN : DS_RUN;
      DS_ALIGN:
        if (dif.tick && good && cnt_ff >= ALIGN_T)
          nxt_state = DS_RUN;
      DS_RUN: nxt_state = DS_RUN;
      DS_ERR: nxt_state = DS_ERR;
      default: nxt_state = DS_ERR;
    endcase
    if (dif.error)
      nxt_state = DS_ERR;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_ff <= DS_TEST;
    else
      state_ff <= nxt_state;
  end

  // dwell counter; in alignment it measures unbroken good alignment
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt_ff <= 17'h0;
    else if (nxt_state != state_ff || (state_ff == DS_TEST && last))
      cnt_ff <= 17'h0;
    else if (state_ff == DS_ALIGN && !good)
      cnt_ff <= 17'h0;
    else if (dif.tick && state_ff != DS_RUN && state_ff != DS_ERR)
      cnt_ff <= cnt_ff + 17'h1;
  end

  // segment walk index during the lamp test
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      step_ff <= 3'h0;
    else if (state_ff == DS_TEST && last && step_ff != 3'h6)
      step_ff <= step_ff + 3'h1;
  end

  // symbol per state, registered one cycle behind the state
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      seg_ff <= `SLC_SEG_BLANK;
    else
      unique case (state_ff)
        DS_TEST: seg_ff <= 8'(8'h01 << step_ff);
        DS_RANGE: seg_ff <= `SLC_SEG_RANGE;
        DS_ROLE: seg_ff <= (dif.role == 2'h0) ? `SLC_SEG_HOST
          : (dif.role == 2'h1) ? `SLC_SEG_GUEST1 : `SLC_SEG_GUEST2;
        DS_CODE: seg_ff <= (dif.coding == 2'h0) ? `SLC_SEG_CODE0
          : (dif.coding == 2'h1) ? `SLC_SEG_CODE1 : `SLC_SEG_CODE2;
        DS_ALIGN: seg_ff <= good
          ? (dif.marker ? `SLC_SEG_MARK : `SLC_SEG_BLANK)
          : (dif.align_q == 2'h0) ? `SLC_SEG_ALIGN0
          : (dif.align_q == 2'h1) ? `SLC_SEG_ALIGN1
          : `SLC_SEG_ALIGN2;
        DS_RUN: seg_ff <= dif.marker ? `SLC_SEG_MARK
          : `SLC_SEG_BLANK;
        DS_ERR: seg_ff <= `SLC_SEG_ERROR;
        default: seg_ff <= `SLC_SEG_ERROR;
      endcase
  end

  // operational once the power-up display reaches alignment or run
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ready_ff <= 1'b0;
    else
      ready_ff <= (state_ff == DS_ALIGN) || (state_ff == DS_RUN);
  end

  assign dif.seg = seg_ff;
  assign dif.ready = ready_ff;
endmodule

// File: design/slc_ctrl.sv
`timescale 1ns/100ps
`include "slc_defs.svh"
module slc_ctrl
  import slc_pkg::*;
#(
  parameter int TICK_CYCLES = `SLC_TICK_CYC,
  parameter int ALIGN_TICKS = `SLC_ALIGN_TICKS
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic is_receiver,
  input wire logic field_clear,
  input wire logic [1:0] align_quality,
  input wire logic cfg_wr,
  input wire logic cfg_edm_en,
  input wire logic cfg_restart_il,
  input wire logic cfg_large_range,
  input wire logic [1:0] cfg_coding,
  input wire logic cfg_reduced_res,
  input wire logic cfg_blanking,
  input wire logic nv_edm_stored,
  input wire logic feedback_pin,
  input wire logic restart_btn_pin,
  input wire logic test_in_pin,
  input wire logic [1:0] role_sel_in_pin,
  output logic safety_output_a,
  output logic safety_output_b,
  output logic [7:0] seg,
  output logic [1:0] role_sel_out,
  output logic ext_test_req,
  output logic restart_required,
  output logic edm_fault,
  output logic device_error,
  output logic nv_edm_wr,
  output logic nv_edm_data
);
  localparam logic [16:0] TICK_C = 17'(TICK_CYCLES);
  localparam logic [8:0] EDM_T = 9'(`SLC_EDM_TICKS);

  if (TICK_CYCLES < 1 || TICK_CYCLES >= 131072)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  slc_disp_if dif ();

  slc_safe_t state_ff, nxt_state;
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  logic btn_prev_ff;
  logic [16:0] tick_cnt_ff;
  logic tick_ff;
  logic [8:0] edm_cnt_ff;
  logic nv_load_ff;
  logic edm_en_ff;
  logic restart_il_ff;
  logic large_range_ff;
  logic [1:0] coding_ff;
  logic marker_ff;
  logic [1:0] role_ff;
  logic err_ff;
  logic fb;
  logic btn_press;
  logic edm_ok;
  logic ossd_a_ff;
  logic ossd_b_ff;
  logic [1:0] role_out_ff;
  logic test_req_ff;
  logic rr_ff;
  logic edm_fault_ff;
  logic nv_wr_ff;
  logic nv_data_ff;

  // two flip-flops on every pin input before any logic reads it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_ff <= `SLC_RST_PINS;
      pin_sync_ff <= `SLC_RST_PINS;
    end
    else
    begin
      pin_meta_ff <= {role_sel_in_pin, test_in_pin, restart_btn_pin,
        feedback_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign fb = pin_sync_ff[`SLC_PIN_FB];
  assign btn_press = pin_sync_ff[`SLC_PIN_BTN] && !btn_prev_ff;
  // contactors must sit at rest before a restart is allowed
  assign edm_ok = !edm_en_ff || fb;

  // button edge detect on the synchronised level only
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      btn_prev_ff <= 1'b0;
    else
      btn_prev_ff <= pin_sync_ff[`SLC_PIN_BTN];
  end

  // 1 ms tick divider; all slow timing counts these pulses
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_ff <= 17'h0;
      tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff == TICK_C - 17'h1)
    begin
      tick_cnt_ff <= 17'h0;
      tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 17'h1;
      tick_ff <= 1'b0;
    end
  end

  // edm mode survives power cycles: loaded from the store after
  // reset release, written back on every configuration write after that load cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      nv_load_ff <= 1'b1;
      edm_en_ff <= `SLC_RST_EDM;
    end
    else if (nv_load_ff)
    begin
      nv_load_ff <= 1'b0;
      edm_en_ff <= nv_edm_stored;
    end
    else if (cfg_wr)
      edm_en_ff <= cfg_edm_en;
  end

  // store write strobe, one cycle per configuration write outside the load cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      nv_wr_ff <= 1'b0;
      nv_data_ff <= `SLC_RST_EDM;
    end
    else
    begin
      nv_wr_ff <= cfg_wr && !nv_load_ff;
      if (cfg_wr && !nv_load_ff)
        nv_data_ff <= cfg_edm_en;
    end
  end

  // volatile settings; interlock off until software enables it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      restart_il_ff <= `SLC_RST_RESTART_IL;
      large_range_ff <= `SLC_RST_CFG;
      coding_ff <= `SLC_RST_CODING;
      marker_ff <= `SLC_RST_CFG;
    end
    else if (cfg_wr)
    begin
      restart_il_ff <= cfg_restart_il;
      large_range_ff <= cfg_large_range;
      coding_ff <= cfg_coding;
      marker_ff <= cfg_reduced_res || cfg_blanking;
    end
  end

  // cascade role from the select pins, next role passed on;
  // code 3 on the input is taken as the last guest
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      role_ff <= 2'h0;
      role_out_ff <= 2'h1;
    end
    else
    begin
      role_ff <= pin_sync_ff[`SLC_PIN_ROLE +: 2];
      unique case (pin_sync_ff[`SLC_PIN_ROLE +: 2])
        2'h0: role_out_ff <= 2'h1;
        2'h1: role_out_ff <= 2'h2;
        default: role_out_ff <= 2'h3;
      endcase
    end
  end

  // feedback seen at 24V while edm is off means miswiring; latched
  // until reset so a flapping contact cannot clear it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      err_ff <= 1'b0;
    else if (is_receiver && !nv_load_ff && !edm_en_ff && fb)
      err_ff <= 1'b1;
  end

  // safety output sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SF_OFF:
        if (field_clear && dif.ready && edm_ok)
          nxt_state = restart_il_ff ? SF_ARMED : SF_CHECK;
      SF_ARMED:
        if (!field_clear)
          nxt_state = SF_OFF;
        else if (btn_press && edm_ok)
          nxt_state = SF_CHECK;
      SF_CHECK:
        if (!field_clear)
          nxt_state = SF_OFF;
        else if (!edm_en_ff || !fb)
          nxt_state = SF_ON;
        else if (tick_ff && edm_cnt_ff >= EDM_T - 9'h1)
          nxt_state = SF_OFF;
      SF_ON:
        if (!field_clear)
          nxt_state = SF_OFF;
      SF_ERR: nxt_state = SF_ERR;
      default: nxt_state = SF_ERR;
    endcase
    if (err_ff || !is_receiver)
      nxt_state = err_ff ? SF_ERR : SF_OFF;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_ff <= SF_OFF;
    else
      state_ff <= nxt_state;
  end

  // time allowed for the contactors to pull in after switch-on
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      edm_cnt_ff <= 9'h0;
    else if (state_ff != SF_CHECK)
      edm_cnt_ff <= 9'h0;
    else if (tick_ff)
      edm_cnt_ff <= edm_cnt_ff + 9'h1;
  end

  // both outputs from the same next state; separate flops so a
  // stuck flop on one channel does not hide the other
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ossd_a_ff <= 1'b0;
      ossd_b_ff <= 1'b0;
    end
    else
    begin
      ossd_a_ff <= (nxt_state == SF_CHECK) || (nxt_state == SF_ON);
      ossd_b_ff <= (nxt_state == SF_CHECK) || (nxt_state == SF_ON);
    end
  end

  // status levels
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rr_ff <= 1'b0;
      edm_fault_ff <= 1'b0;
      test_req_ff <= 1'b0;
    end
    else
    begin
      rr_ff <= (nxt_state == SF_ARMED);
      if (state_ff == SF_CHECK && nxt_state == SF_OFF && field_clear)
        edm_fault_ff <= 1'b1;
      else if (nxt_state == SF_ON)
        edm_fault_ff <= 1'b0;
      // sender: 0V on the test pin asks for an external test
      test_req_ff <= !is_receiver && !pin_sync_ff[`SLC_PIN_TEST];
    end
  end

  // display sequencer
  assign dif.tick = tick_ff;
  assign dif.receiver = is_receiver;
  assign dif.large_range = large_range_ff;
  assign dif.marker = marker_ff;
  assign dif.error = err_ff;
  assign dif.align_q = align_quality;
  assign dif.role = role_ff;
  assign dif.coding = coding_ff;

  slc_disp #(
    .ALIGN_TICKS(ALIGN_TICKS)
  ) u_disp (
    .core_clk(core_clk),
    .reset(reset),
    .dif(dif)
  );

  assign safety_output_a = ossd_a_ff;
  assign safety_output_b = ossd_b_ff;
  assign seg = dif.seg;
  assign role_sel_out = role_out_ff;
  assign ext_test_req = test_req_ff;
  assign restart_required = rr_ff;
  assign edm_fault = edm_fault_ff;
  assign device_error = err_ff;
  assign nv_edm_wr = nv_wr_ff;
  assign nv_edm_data = nv_data_ff;
endmodule

// File: sim/slc_ctrl_checker.sv
`timescale 1ns/100ps
module slc_ctrl_checker
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic is_receiver,
  input wire logic field_clear,
  input wire logic test_in_pin,
  input wire logic [1:0] role_sel_in_pin,
  input wire logic cfg_wr,
  input wire logic cfg_edm_en,
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire logic [1:0] role_sel_out,
  input wire logic ext_test_req,
  input wire logic restart_required,
  input wire logic edm_fault,
  input wire logic device_error,
  input wire logic nv_edm_wr,
  input wire logic nv_edm_data
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // redundant pair must never disagree
  property p_pair;
    safety_output_a == safety_output_b;
  endproperty
  property p_drop;
    !field_clear |-> ##[1:3] !safety_output_a;
  endproperty
  property p_sender;
    !is_receiver |-> !safety_output_a;
  endproperty
  // two sync flops plus the output register
  property p_test;
    (!is_receiver && !test_in_pin) [*3] |=> ext_test_req;
  endproperty
  property p_role;
    (role_sel_in_pin == 2'h1) [*4] |-> role_sel_out == 2'h2;
  endproperty
  property p_err;
    device_error |=> device_error && !safety_output_a;
  endproperty
  property p_fault;
    $rose(edm_fault) |-> ##[0:1] !safety_output_a;
  endproperty
  property p_nv;
    nv_edm_wr |-> $past(cfg_wr) && nv_edm_data == $past(cfg_edm_en);
  endproperty
  property p_wait;
    restart_required [*3] |-> !safety_output_a;
  endproperty
  a_pair: assert property (p_pair)
    else $error("safety outputs differ");
  a_drop: assert property (p_drop)
    else $error("outputs stay on with field blocked");
  a_sender: assert property (p_sender)
    else $error("sender drives outputs on");
  a_test: assert property (p_test)
    else $error("test request missing");
  a_role: assert property (p_role)
    else $error("next role wrong");
  a_err: assert property (p_err)
    else $error("error not held with outputs off");
  a_fault: assert property (p_fault)
    else $error("outputs on after feedback timeout");
  a_nv: assert property (p_nv)
    else $error("store write without config");
  a_wait: assert property (p_wait)
    else $error("outputs on while restart pending");
  c_fault: cover property ($rose(edm_fault));
  c_err: cover property ($rose(device_error));
  c_wait: cover property (restart_required ##1 !restart_required);
endmodule

// File: sim/slc_machine.sv
`timescale 1ns/100ps
module slc_machine
(
  input wire logic core_clk,
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire logic wired,
  input wire logic [1:0] fault,
  input wire logic press,
  output logic feedback_pin,
  output logic restart_btn_pin
);
  logic [3:0] pull_a_ff = 4'h0;
  logic [3:0] pull_b_ff = 4'h0;
  // contactor armature lags its coil by a few clocks
  always_ff @(posedge core_clk)
  begin
    pull_a_ff <= {pull_a_ff[2:0], safety_output_a};
    pull_b_ff <= {pull_b_ff[2:0], safety_output_b};
  end
  // n/c contacts in series: 24 V only with both at rest
  always_comb
  begin
    if (!wired)
      feedback_pin = 1'h0;
    else if (fault == 2'h1)
      feedback_pin = 1'h1;
    else if (fault == 2'h2)
      feedback_pin = 1'h0;
    else
      feedback_pin = !pull_a_ff[3] && !pull_b_ff[3];
  end
  assign restart_btn_pin = press;
endmodule

// File: sim/tb_slc_ctrl.sv
`timescale 1ns/100ps
module tb_slc_ctrl;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic is_receiver = 1'h1;
  logic field_clear = 1'h0;
  logic cfg_wr = 1'h0;
  logic cfg_edm_en = 1'h0;
  logic cfg_restart_il = 1'h0;
  logic cfg_large_range = 1'h1;
  logic cfg_reduced_res = 1'h0;
  logic cfg_blanking = 1'h0;
  logic nv_edm_stored = 1'h0;
  logic test_in_pin = 1'h1;
  logic wired = 1'h0;
  logic press = 1'h0;
  logic [1:0] align_quality = 2'h0;
  logic [1:0] cfg_coding = 2'h1;
  logic [1:0] role_sel_in_pin = 2'h0;
  logic [1:0] fault = 2'h0;
  logic safety_output_a, safety_output_b, feedback_pin, restart_btn_pin;
  logic ext_test_req, restart_required, edm_fault, device_error;
  logic nv_edm_wr, nv_edm_data;
  logic [7:0] seg;
  logic [1:0] role_sel_out;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  slc_ctrl #(.TICK_CYCLES(10), .ALIGN_TICKS(20)) dut
  (
    .core_clk, .reset, .is_receiver, .field_clear, .align_quality,
    .cfg_wr, .cfg_edm_en, .cfg_restart_il, .cfg_large_range, .cfg_coding,
    .cfg_reduced_res, .cfg_blanking, .nv_edm_stored, .feedback_pin,
    .restart_btn_pin, .test_in_pin, .role_sel_in_pin, .safety_output_a,
    .safety_output_b, .seg, .role_sel_out, .ext_test_req,
    .restart_required, .edm_fault, .device_error, .nv_edm_wr, .nv_edm_data
  );
  slc_machine mach
  (
    .core_clk, .safety_output_a, .safety_output_b, .wired, .fault,
    .press, .feedback_pin, .restart_btn_pin
  );
  always #4 core_clk = ~core_clk;
  // hang guard, well above the longest expected run
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // settle just past the edge before looking
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task wait_seg(input logic [7:0] e);
    int i;
    i = 0;
    while (seg !== e && i < 8000)
    begin
      cyc(1);
      i++;
    end
    chk("seg", e, seg);
  endtask
  task cfg(input logic contactor_feedback_monitor, il, rr);
    @(posedge core_clk) cfg_wr <= 1'h1;
    cfg_edm_en <= contactor_feedback_monitor;
    cfg_restart_il <= il;
    cfg_reduced_res <= rr;
    @(posedge core_clk) cfg_wr <= 1'h0;
    cyc(0);
    chk("nv_wr", 8'h01, nv_edm_wr);
    chk("nv_data", contactor_feedback_monitor, nv_edm_data);
  endtask
  initial
  begin
    cyc(9);
    @(posedge core_clk) reset <= 1'h0;
    cyc(2);
    cfg(1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 7; i++)
      wait_seg(8'h01 << i);
    wait_seg(8'h76);
    wait_seg(8'h74);
    wait_seg(8'h01);
    wait_seg(8'hbf);
    @(posedge core_clk) align_quality <= 2'h1;
    wait_seg(8'h86);
    @(posedge core_clk) align_quality <= 2'h2;
    wait_seg(8'h5b);
    @(posedge core_clk) align_quality <= 2'h3;
    wait_seg(8'h00);
    cyc(400);
    @(posedge core_clk) align_quality <= 2'h0;
    cyc(20);
    chk("seg", 8'h00, seg);
    @(posedge core_clk) field_clear <= 1'h1;
    cyc(4);
    chk("out_a", 8'h01, safety_output_a);
    chk("out_b", 8'h01, safety_output_b);
    @(posedge core_clk) field_clear <= 1'h0;
    cyc(4);
    chk("out_b", 8'h00, safety_output_b);
    cfg(1'h0, 1'h1, 1'h1);
    cyc(3);
    chk("seg", 8'h5c, seg);
    @(posedge core_clk) field_clear <= 1'h1;
    cyc(6);
    chk("out_a", 8'h00, safety_output_a);
    chk("restart", 8'h01, restart_required);
    @(posedge core_clk) press <= 1'h1;
    cyc(6);
    chk("out_a", 8'h01, safety_output_a);
    @(posedge core_clk) press <= 1'h0;
    field_clear <= 1'h0;
    cfg(1'h1, 1'h1, 1'h0);
    @(posedge core_clk) wired <= 1'h1;
    fault <= 2'h2;
    field_clear <= 1'h1;
    cyc(20);
    @(posedge core_clk) press <= 1'h1;
    cyc(10);
    chk("out_a", 8'h00, safety_output_a);
    @(posedge core_clk) press <= 1'h0;
    fault <= 2'h0;
    cyc(20);
    @(posedge core_clk) press <= 1'h1;
    cyc(10);
    chk("out_a", 8'h01, safety_output_a);
    chk("edm_fault", 8'h00, edm_fault);
    @(posedge core_clk) press <= 1'h0;
    field_clear <= 1'h0;
    cyc(30);
    @(posedge core_clk) fault <= 2'h1;
    field_clear <= 1'h1;
    cyc(10);
    @(posedge core_clk) press <= 1'h1;
    cyc(2900);
    chk("out_a", 8'h01, safety_output_a);
    cyc(200);
    chk("out_a", 8'h00, safety_output_a);
    chk("edm_fault", 8'h01, edm_fault);
    @(posedge core_clk) press <= 1'h0;
    field_clear <= 1'h0;
    fault <= 2'h0;
    cfg(1'h0, 1'h0, 1'h0);
    cyc(10);
    chk("dev_err", 8'h01, device_error);
    wait_seg(8'hf9);
    // second power-up as a sender, first guest, then second guest
    @(posedge core_clk) reset <= 1'h1;
    is_receiver <= 1'h0;
    test_in_pin <= 1'h0;
    role_sel_in_pin <= 2'h1;
    wired <= 1'h0;
    cyc(9);
    @(posedge core_clk) reset <= 1'h0;
    cyc(6);
    chk("test_req", 8'h01, ext_test_req);
    chk("role_out", 8'h02, role_sel_out);
    // code 2 and blanking, written during the lamp test
    @(posedge core_clk) cfg_coding <= 2'h2;
    cfg_blanking <= 1'h1;
    cfg(1'h0, 1'h0, 1'h0);
    @(posedge core_clk) role_sel_in_pin <= 2'h2;
    cyc(4);
    chk("role_out", 8'h03, role_sel_out);
    wait_seg(8'h3e);
    wait_seg(8'h08);
    wait_seg(8'h5c);
    @(posedge core_clk) field_clear <= 1'h1;
    test_in_pin <= 1'h1;
    cyc(6);
    chk("test_req", 8'h00, ext_test_req);
    chk("out_a", 8'h00, safety_output_a);
    // third power-up as receiver: stored edm mode must come back,
    // so feedback at 24 V is no miswire
    @(posedge core_clk) reset <= 1'h1;
    is_receiver <= 1'h1;
    nv_edm_stored <= 1'h1;
    wired <= 1'h1;
    cyc(9);
    @(posedge core_clk) reset <= 1'h0;
    cyc(10);
    chk("dev_err", 8'h00, device_error);
    end_sim();
  end
endmodule
bind slc_ctrl slc_ctrl_checker u_chk
(
  .core_clk, .reset, .is_receiver, .field_clear, .test_in_pin,
  .role_sel_in_pin, .cfg_wr, .cfg_edm_en, .safety_output_a,
  .safety_output_b, .role_sel_out, .ext_test_req, .restart_required,
  .edm_fault, .device_error, .nv_edm_wr, .nv_edm_data
);
